// File: hdl/itsc_pkg.sv
package itsc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] REG_IDX_TRAP_CTRL = 16'h7C72;
  localparam logic [15:0] REG_IDX_CAP_ADDR = 16'h8472;
  localparam int WB_ADR_W = 18;

  // Trap control/status field positions
  localparam int BIT_LOCAL_ATTENTION_SMI_ENABLE = 15;
  localparam int BIT_NAC_HI = 14;
  localparam int BIT_NAC_LO = 13;
  localparam int BIT_PCS1_TE = 12;
  localparam int BIT_PCS2_TE = 11;
  localparam int BIT_SERA_TE = 10;
  localparam int BIT_SERB_TE = 9;
  localparam int BIT_PAR_TE = 8;
  localparam int BIT_TRAP = 7;
  localparam int BIT_WRITE = 6;
  localparam int BIT_IOS_HI = 5;
  localparam int BIT_IOS_LO = 3;
  localparam int BIT_MS_HI = 2;
  localparam int BIT_MS_LO = 0;

  // Reset values
  localparam logic [7:0] RST_CTRL_HI = 8'h00;
  localparam logic [2:0] RST_CODE = 3'h0;
  localparam logic [15:0] RST_CAP_ADDR = 16'h0000;

  // Chip select hit vector order
  localparam int CS_PCS1 = 0;
  localparam int CS_PCS2 = 1;
  localparam int CS_SERA = 2;
  localparam int CS_SERB = 3;
  localparam int CS_PAR = 4;
  localparam int CS_N = 5;

  // Next-address control modes
  typedef enum logic [1:0] {
    NAC_OFF = 2'h0,
    NAC_ON = 2'h1,
    NAC_RSVD = 2'h2,
    NAC_IO_BREAK = 2'h3
  } itsc_nac_t;

  // Transfer size of an instruction's operand
  typedef enum logic [1:0] {
    SZ_8 = 2'h0,
    SZ_16 = 2'h1,
    SZ_32 = 2'h2
  } itsc_size_t;

  // Size/status codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_16 = 3'h1;
  localparam logic [2:0] CODE_32 = 3'h2;
  localparam logic [2:0] CODE_32_M2 = 3'h3;
  localparam logic [2:0] CODE_32_M1 = 3'h4;
  localparam logic [2:0] CODE_8 = 3'h5;
  localparam logic [2:0] CODE_16_UA = 3'h6;
  localparam logic [2:0] CODE_32_M3 = 3'h7;

  // One processor bus cycle, presented for one clock
  typedef struct packed {
    logic valid;
    logic is_io;
    logic write;
    logic copro;
    logic string_in;
    itsc_size_t size;
    logic [15:0] addr;
  } itsc_cycle_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [WB_ADR_W-1:2] adr;
    logic [31:0] dat;
  } itsc_wb_req_t;

endpackage

// File: hdl/itsc_size_enc.sv
module itsc_size_enc (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic load_i,
  input wire itsc_pkg::itsc_size_t size_i,
  input wire logic [1:0] addr_lo_i,
  // Status
  output logic [2:0] code_o
);

  logic [2:0] code_ff;
  logic [2:0] nxt_code;
  logic [2:0] enc_code;

  // Misaligned operands keep the offset the handler must remove
  assign enc_code = (size_i == itsc_pkg::SZ_8) ? itsc_pkg::CODE_8 :
                    (size_i == itsc_pkg::SZ_16) ?
                      (addr_lo_i[0] ? itsc_pkg::CODE_16_UA : itsc_pkg::CODE_16) :
                    (addr_lo_i == 2'h0) ? itsc_pkg::CODE_32 :
                    (addr_lo_i == 2'h2) ? itsc_pkg::CODE_32_M2 :
                    (addr_lo_i == 2'h1) ? itsc_pkg::CODE_32_M1 :
                    itsc_pkg::CODE_32_M3; // RQ19

  // Load wins over clear so a new first cycle is not lost
  assign nxt_code = load_i ? enc_code : (clear_i ? itsc_pkg::RST_CODE : code_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_ff <= itsc_pkg::RST_CODE;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign code_o = code_ff;

endmodule // itsc_size_enc

// File: hdl/itsc_na_ctrl.sv
module itsc_na_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire itsc_pkg::itsc_nac_t mode_i,
  input wire logic io_first_t_i,
  input wire logic smi_i,
  // Processor pin
  output logic next_address_out_o
);

  logic hold_low_ff;
  logic nxt_hold_low;
  logic io_break;

  assign io_break = (mode_i == itsc_pkg::NAC_IO_BREAK);
  // Remember the break; it keeps the pin low only while SMI is up
  assign nxt_hold_low = io_break & (io_first_t_i | (hold_low_ff & smi_i)); // RQ4

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_low_ff <= 1'b0;
    end else begin
      hold_low_ff <= nxt_hold_low;
    end
  end

  // Reserved mode is treated as nonpipelined, the safe choice
  assign next_address_out_o = (mode_i == itsc_pkg::NAC_ON) |
                              (io_break & ~io_first_t_i & ~(hold_low_ff & smi_i)); // RQ3 RQ4

endmodule // itsc_na_ctrl

// File: hdl/itsc_top.sv
// Operation
// RQ1: Enable bit 15 lets any local attention source raise SMI; off by default.
// RQ2: Attention SMI uses the internal attention level, ignoring output update disables.
// RQ3: Field 14:13: 00 next-address low, 01 always high, 10 reserved.
// RQ4: Mode 11 drops next-address for first I/O T state; back unless SMI.
// RQ5: Software enabling traps with pipelining must select next-address mode 11.
// RQ6: Bit 12 enables traps on program chip select 1 accesses.
// RQ7: Bit 11 traps chip select 2 range even when that select is disabled.
// RQ8: Bit 10 enables traps on serial port A range accesses.
// RQ9: Bit 9 enables traps on serial port B range accesses.
// RQ10: Bit 8 enables traps on parallel port range accesses.
// RQ11: Bit 7 reads one after a trap, zero otherwise.
// RQ12: Writing zero to bit 7 clears all trap status and rearms capture.
// RQ13: Writing one to bit 7 changes nothing in the trap state.
// RQ14: Handler clears the trap bit by writing zero on each service.
// RQ15: Bit 6 shows the trapped cycle was a write; clears on trap clear.
// RQ16: Bits 5:3 hold the I/O size code; clear on reset or clear.
// RQ17: Bits 2:0 record string-input memory writes after trap; clear likewise.
// RQ18: Captured address holds first trapped I/O address; clears on trap clear.
// RQ19: Size codes follow the eight-entry size and adjustment table.
// RQ20: A trapped I/O access asserts SMI to the processor.
// RQ21: Captured data is frozen while the trap bit stays set.
// RQ22: Status keeps collecting follow-on cycles until the instruction ends.
module itsc_top #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire itsc_pkg::itsc_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor bus observation
  input wire itsc_pkg::itsc_cycle_t cycle_i,
  input wire logic [itsc_pkg::CS_N-1:0] cs_hit_i,
  input wire logic instr_end_i,
  input wire logic io_first_t_i,
  // Power management
  input wire logic local_attention_i,
  // Processor pins
  output logic smi_o,
  output logic next_address_out_o
);

  if (ADDR_W != 16) begin : g_chk_addr
    $error("itsc_top: ADDR_W must be 16");
  end

  // Control register fields
  logic local_attention_smi_enable_ff;
  logic [1:0] next_addr_ctrl_ff;
  logic [itsc_pkg::CS_N-1:0] trap_en_ff;
  logic nxt_local_attention_smi_enable;
  logic [1:0] nxt_nac;
  logic [itsc_pkg::CS_N-1:0] nxt_trap_en;

  // Trap state
  logic trap_flag_ff;
  logic trap_write_flag_ff;
  logic capture_open_ff;
  logic [15:0] captured_port_addr_ff;
  logic smi_ff;
  logic nxt_trap_flag;
  logic nxt_write_flag;
  logic nxt_open;
  logic [15:0] nxt_cap_addr;
  logic nxt_smi;
  logic [2:0] io_size_code;
  logic [2:0] mem_write_code;

  // Bus slave state
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;

  // Address decode
  logic bus_req;
  logic wr_commit;
  logic hit_ctrl;
  logic hit_cap;
  logic [itsc_pkg::WB_ADR_W-3:0] idx_ctrl;
  logic [itsc_pkg::WB_ADR_W-3:0] idx_cap;
  logic [15:0] ctrl_rd;

  assign idx_ctrl = itsc_pkg::REG_IDX_TRAP_CTRL;
  assign idx_cap = itsc_pkg::REG_IDX_CAP_ADDR;
  assign bus_req = wb_req_i.cyc & wb_req_i.stb;
  assign hit_ctrl = (wb_req_i.adr == idx_ctrl);
  assign hit_cap = (wb_req_i.adr == idx_cap);
  // Writes land on the edge where the master sees ack
  assign wr_commit = bus_req & wb_req_i.we & ack_ff;

  logic wr_ctrl_lo;
  logic wr_ctrl_hi;
  logic trap_clear;

  assign wr_ctrl_lo = wr_commit & hit_ctrl & wb_req_i.sel[0];
  assign wr_ctrl_hi = wr_commit & hit_ctrl & wb_req_i.sel[1];
  // Writing one leaves trap state alone; only zero clears
  assign trap_clear = wr_ctrl_lo & ~wb_req_i.dat[itsc_pkg::BIT_TRAP]; // RQ12 RQ13

  assign nxt_local_attention_smi_enable = wr_ctrl_hi ? wb_req_i.dat[itsc_pkg::BIT_LOCAL_ATTENTION_SMI_ENABLE] :
                    local_attention_smi_enable_ff;
  assign nxt_nac = wr_ctrl_hi ? wb_req_i.dat[itsc_pkg::BIT_NAC_HI:itsc_pkg::BIT_NAC_LO] :
                   next_addr_ctrl_ff;
  assign nxt_trap_en = wr_ctrl_hi ?
    {wb_req_i.dat[itsc_pkg::BIT_PAR_TE], wb_req_i.dat[itsc_pkg::BIT_SERB_TE],
     wb_req_i.dat[itsc_pkg::BIT_SERA_TE], wb_req_i.dat[itsc_pkg::BIT_PCS2_TE],
     wb_req_i.dat[itsc_pkg::BIT_PCS1_TE]} : trap_en_ff;

  // Trap detection on enabled chip select ranges
  logic io_cycle;
  logic [itsc_pkg::CS_N-1:0] hit_vec;
  logic trap_hit;
  logic first_trap;
  logic mem_capture;
  logic mem_first;

  assign io_cycle = cycle_i.valid & cycle_i.is_io & ~cycle_i.copro;
  // Select-two range is decoded regardless of its own enable
  assign hit_vec = cs_hit_i & trap_en_ff; // RQ6 RQ7 RQ8 RQ9 RQ10
  assign trap_hit = io_cycle & (|hit_vec);
  // A fresh trap only after rearm; a hit during clear still counts
  assign first_trap = trap_hit & (~trap_flag_ff | trap_clear); // RQ21
  assign mem_capture = cycle_i.valid & ~cycle_i.is_io & cycle_i.write &
                       cycle_i.string_in & capture_open_ff & ~trap_clear; // RQ17
  assign mem_first = mem_capture & (mem_write_code == itsc_pkg::CODE_NONE);

  assign nxt_trap_flag = first_trap | (trap_flag_ff & ~trap_clear); // RQ11 RQ12
  assign nxt_write_flag = first_trap ? cycle_i.write :
                          (trap_clear ? 1'b0 : trap_write_flag_ff); // RQ15
  assign nxt_cap_addr = first_trap ? cycle_i.addr :
                        (trap_clear ? itsc_pkg::RST_CAP_ADDR : captured_port_addr_ff); // RQ18
  // Window stays open over follow-on cycles until the instruction ends
  assign nxt_open = first_trap | (capture_open_ff & ~instr_end_i & ~trap_clear); // RQ22

  // SMI from trap or from the internal attention level
  assign nxt_smi = nxt_trap_flag |
                   (local_attention_smi_enable_ff & local_attention_i); // RQ1 RQ2 RQ20

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_attention_smi_enable_ff <= 1'b0;
      next_addr_ctrl_ff <= 2'h0;
      trap_en_ff <= '0;
    end else begin
      local_attention_smi_enable_ff <= nxt_local_attention_smi_enable;
      next_addr_ctrl_ff <= nxt_nac;
      trap_en_ff <= nxt_trap_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_flag_ff <= 1'b0;
      trap_write_flag_ff <= 1'b0;
      capture_open_ff <= 1'b0;
      captured_port_addr_ff <= itsc_pkg::RST_CAP_ADDR;
      smi_ff <= 1'b0;
    end else begin
      trap_flag_ff <= nxt_trap_flag;
      trap_write_flag_ff <= nxt_write_flag;
      capture_open_ff <= nxt_open;
      captured_port_addr_ff <= nxt_cap_addr;
      smi_ff <= nxt_smi;
    end
  end

  itsc_size_enc u_io_size (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(trap_clear),
    .load_i(first_trap),
    .size_i(cycle_i.size),
    .addr_lo_i(cycle_i.addr[1:0]),
    .code_o(io_size_code)
  ); // RQ16 RQ19

  itsc_size_enc u_mem_size (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(trap_clear),
    .load_i(mem_first),
    .size_i(cycle_i.size),
    .addr_lo_i(cycle_i.addr[1:0]),
    .code_o(mem_write_code)
  ); // RQ17

  itsc_na_ctrl u_na (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(itsc_pkg::itsc_nac_t'(next_addr_ctrl_ff)),
    .io_first_t_i(io_first_t_i),
    .smi_i(smi_ff),
    .next_address_out_o(next_address_out_o)
  ); // RQ3 RQ4

  // Read mux; unmapped addresses read as zero
  assign ctrl_rd = {local_attention_smi_enable_ff, next_addr_ctrl_ff,
                    trap_en_ff[itsc_pkg::CS_PCS1], trap_en_ff[itsc_pkg::CS_PCS2],
                    trap_en_ff[itsc_pkg::CS_SERA], trap_en_ff[itsc_pkg::CS_SERB],
                    trap_en_ff[itsc_pkg::CS_PAR], trap_flag_ff, trap_write_flag_ff,
                    io_size_code, mem_write_code}; // RQ11 RQ15 RQ16 RQ17
  assign nxt_dat = (bus_req & ~ack_ff) ?
                   (hit_ctrl ? {16'h0000, ctrl_rd} :
                    hit_cap ? {16'h0000, captured_port_addr_ff} : 32'h0000_0000) :
                   dat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign smi_o = smi_ff;

endmodule // itsc_top

// File: tb/itsc_asserts.sv
module itsc_asserts #(
  parameter int ADDR_W = 16
) (
  // Watched inputs
  input wire logic clk_i,
  input wire logic rst_i,
  input wire itsc_pkg::itsc_wb_req_t wb_req_i,
  input wire itsc_pkg::itsc_cycle_t cycle_i,
  input wire logic [itsc_pkg::CS_N-1:0] cs_hit_i,
  input wire logic instr_end_i,
  input wire logic io_first_t_i,
  input wire logic local_attention_i,
  // Watched outputs
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic smi_o,
  input wire logic next_address_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [4:0] en;
  // Shadow of the control byte, taken at the edge where the slave commits
  assign nxt_ctl = (wb_ack_o && wb_req_i.we && wb_req_i.sel[1] &&
    wb_req_i.adr == itsc_pkg::REG_IDX_TRAP_CTRL) ? wb_req_i.dat[15:8] : ctl_ff;
  assign en = {ctl_ff[0], ctl_ff[1], ctl_ff[2], ctl_ff[3], ctl_ff[4]};
  always_ff @(posedge clk_i) begin
    ctl_ff <= rst_i ? 8'h00 : nxt_ctl;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  endsequence
  sequence s_hit;
    cycle_i.valid && cycle_i.is_io && !cycle_i.copro && (cs_hit_i & en) != 5'h00;
  endsequence
  sequence s_brk;
    ctl_ff[6:5] == 2'h3 && io_first_t_i;
  endsequence
  AST_NA_HOLD: assert property (s_brk ##1 (ctl_ff[6:5] == 2'h3 && !io_first_t_i && smi_o)
    |-> !next_address_out_o)
    else $error("next address restored while smi active");
  AST_ACK: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_TRAP_SMI: assert property (s_hit |=> smi_o)
    else $error("trapped cycle gave no smi");
  AST_LA_SMI: assert property (ctl_ff[7] && local_attention_i |=> smi_o)
    else $error("attention gave no smi");
  AST_NA_OFF: assert property (!ctl_ff[5] |-> !next_address_out_o)
    else $error("next address driven in mode 00 or 10");
  AST_NA_ON: assert property (ctl_ff[6:5] == 2'h1 |-> next_address_out_o)
    else $error("next address low in mode 01");
  AST_NA_BRK: assert property (ctl_ff[6:5] == 2'h3 && io_first_t_i |-> !next_address_out_o)
    else $error("next address not broken on io cycle");
  AST_NA_BACK: assert property (ctl_ff[6:5] == 2'h3 && !io_first_t_i && !smi_o
    |-> next_address_out_o)
    else $error("next address not restored");
endmodule // itsc_asserts

bind itsc_top itsc_asserts #(.ADDR_W(ADDR_W)) u_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .cycle_i(cycle_i), .cs_hit_i(cs_hit_i), .instr_end_i(instr_end_i),
  .io_first_t_i(io_first_t_i), .local_attention_i(local_attention_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .smi_o(smi_o), .next_address_out_o(next_address_out_o));

// File: tb/itsc_cpu_model.sv
module itsc_cpu_model (
  // Clock
  input wire logic clk_i,
  // Processor bus activity
  output itsc_pkg::itsc_cycle_t cycle_o,
  output logic [itsc_pkg::CS_N-1:0] cs_hit_o,
  output logic instr_end_o,
  output logic io_first_t_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cycle_o = '0;
    cs_hit_o = '0;
    instr_end_o = 1'b0;
    io_first_t_o = 1'b0;
  end
  task automatic go(input logic io, wr, cp, si, input logic [1:0] sz,
    input logic [15:0] a, input logic [4:0] h);
    @(posedge clk_i);
    cycle_o <= '{1'b1, io, wr, cp, si, itsc_pkg::itsc_size_t'(sz), a};
    cs_hit_o <= h;
    // Coprocessor cycles never break next-address
    io_first_t_o <= io && !cp;
  endtask
  task automatic stop(input logic fin);
    @(posedge clk_i);
    cycle_o.valid <= 1'b0;
    // Released lines show a changed pattern, not the last value
    cycle_o.addr <= ~cycle_o.addr;
    cs_hit_o <= ~cs_hit_o;
    io_first_t_o <= 1'b0;
    instr_end_o <= fin;
    @(posedge clk_i);
    instr_end_o <= 1'b0;
  endtask
endmodule // itsc_cpu_model

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CTL = itsc_pkg::REG_IDX_TRAP_CTRL;
  localparam logic [15:0] CAP = itsc_pkg::REG_IDX_CAP_ADDR;
  localparam logic [1:0] SZ [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
  localparam logic [1:0] LO [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h3};
  localparam logic [2:0] CODE [7] = '{3'h5, 3'h1, 3'h6, 3'h2, 3'h3, 3'h4, 3'h7};
  itsc_pkg::itsc_wb_req_t req;
  itsc_pkg::itsc_cycle_t cyc;
  logic [31:0] dat;
  logic [4:0] hit;
  logic clk, rst, ack, fin, ft, la, smi, na;
  int errors;
  int cmp_count;
  itsc_top #(.ADDR_W(16)) DUT (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .cycle_i(cyc), .cs_hit_i(hit), .instr_end_i(fin), .io_first_t_i(ft),
    .local_attention_i(la), .smi_o(smi), .next_address_out_o(na));
  itsc_cpu_model cpu (.clk_i(clk), .cycle_o(cyc), .cs_hit_o(hit), .instr_end_o(fin),
    .io_first_t_o(ft));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wb(input logic we, input logic [3:0] s, input logic [15:0] a, d,
    output logic [15:0] q);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, s, a, {16'h0000, d}};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chkb(ack, 1'b1);
    q = dat[15:0];
    chk(dat[31:16], 16'h0000);
    req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, exp);
    logic [15:0] q;
    wb(1'b0, 4'h3, a, 16'h0000, q);
    chk(q, exp);
  endtask
  task automatic wrs(input logic [3:0] s, input logic [15:0] a, d);
    logic [15:0] q;
    wb(1'b1, s, a, d, q);
  endtask
  task automatic wr(input logic [15:0] a, d);
    wrs(4'h3, a, d);
  endtask
  task automatic t_reset;
    rd(CTL, 16'h0000);
    rd(CAP, 16'h0000);
    wr(16'h0001, 16'hFFFF);
    rd(16'h0001, 16'h0000);
    wr(CAP, 16'hFFFF);
    rd(CAP, 16'h0000);
    // Byte lanes gate the two halves separately
    wrs(4'h1, CTL, 16'hFFFF);
    rd(CTL, 16'h0000);
    wrs(4'h2, CTL, 16'h1F00);
    rd(CTL, 16'h1F00);
    wrs(4'hC, CTL, 16'h0000);
    rd(CTL, 16'h1F00);
    wr(CTL, 16'h0000);
  endtask
  task automatic t_la;
    @(posedge clk);
    la <= 1'b1;
    repeat (2) @(negedge clk);
    chkb(smi, 1'b0);
    wr(CTL, 16'h8000);
    repeat (2) @(negedge clk);
    chkb(smi, 1'b1);
    @(posedge clk);
    la <= 1'b0;
    wr(CTL, 16'h0000);
    repeat (2) @(negedge clk);
    chkb(smi, 1'b0);
  endtask
  task automatic t_na;
    for (int m = 0; m < 4; m++) begin
      wr(CTL, {1'b0, 2'(m), 13'h0000});
      @(negedge clk);
      chkb(na, m[0]);
      cpu.go(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0080, 5'h00);
      @(negedge clk);
      chkb(na, m == 1);
      cpu.stop(1'b0);
      @(negedge clk);
      chkb(na, m[0]);
    end
  endtask
  task automatic t_trap;
    logic [15:0] a, en, exp;
    int c;
    for (int i = 0; i < 7; i++) begin
      c = i % 5;
      a = {10'h0E0, i[3:0], LO[i]};
      en = 16'h6000 | (16'h1000 >> c);
      exp = en | 16'h0080 | {9'h000, i[0], CODE[i], CODE[i]};
      wr(CTL, en);
      cpu.go(1'b1, i[0], 1'b0, 1'b0, SZ[i], a, 5'h01 << ((c + 1) % 5));
      cpu.stop(1'b0);
      cpu.go(1'b1, i[0], 1'b1, 1'b0, SZ[i], a, 5'h01 << c);
      cpu.stop(1'b0);
      @(negedge clk);
      chkb(smi, 1'b0);
      cpu.go(1'b1, i[0], 1'b0, 1'b0, SZ[i], a, 5'h01 << c);
      cpu.stop(1'b0);
      cpu.go(1'b0, 1'b1, 1'b0, 1'b1, SZ[i], 16'h4000 | LO[i], 5'h00);
      cpu.stop(1'b0);
      // Later trap while flagged must not disturb the capture
      cpu.go(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, ~a, 5'h1F);
      cpu.stop(1'b1);
      @(negedge clk);
      chkb(smi, 1'b1);
      chkb(na, 1'b0);
      rd(CTL, exp);
      rd(CAP, a);
      wr(CTL, en | 16'h0080);
      rd(CTL, exp);
      wr(CTL, en);
      rd(CTL, en);
      rd(CAP, 16'h0000);
      @(negedge clk);
      chkb(smi, 1'b0);
      chkb(na, 1'b1);
    end
  endtask
  task automatic t_win;
    wr(CTL, 16'h7000);
    cpu.go(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0100, 5'h01);
    cpu.stop(1'b1);
    // Memory write after the instruction ended stays out of the status
    cpu.go(1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 16'h4000, 5'h00);
    cpu.stop(1'b0);
    @(negedge clk);
    chkb(smi, 1'b1);
    rd(CTL, 16'h70A8);
    rd(CAP, 16'h0100);
    wr(CTL, 16'h7000);
    rd(CTL, 16'h7000);
  endtask
  task automatic t_rst;
    wr(CTL, 16'h9F00);
    @(posedge clk);
    la <= 1'b1;
    cpu.go(1'b1, 1'b1, 1'b0, 1'b0, 2'h1, 16'h0300, 5'h10);
    cpu.stop(1'b1);
    @(negedge clk);
    chkb(smi, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chkb(smi, 1'b0);
    chkb(ack, 1'b0);
    chkb(na, 1'b0);
    rd(CTL, 16'h0000);
    rd(CAP, 16'h0000);
    la <= 1'b0;
  endtask
  task automatic end_sim;
    $display("errors %0d, compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    req = '0;
    la = 1'b0;
    rst = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_la;
    t_na;
    t_trap;
    t_win;
    t_rst;
    end_sim;
  end
  // Run needs about 400 cycles; over twenty times that before giving up
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
endmodule // testbench
